// ==== src/pir_regs.svh ====
// Purpose: Offsets, field positions and build values of the ident/build-option bank
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: Build values are plain defaults; the ident code value is arbitrary
`ifndef PIR_REGS_SVH
`define PIR_REGS_SVH
`define PIR_ADDR_W 8
`define PIR_OFF_IDENT_CODE 8'h64
`define PIR_OFF_COMP_VERSION 8'h6c
`define PIR_OFF_BUILD_OPT1 8'h74
// Arbitrary identification code
`define PIR_IDENT_CODE_VAL 16'h3c5a
// ASCII version digits
`define PIR_COMP_VERSION_VAL 32'h3130305f
`define PIR_IDENT_FIELD_WIDTH_PARAM 6'h10
`define PIR_IDENT_REG_PRESENT 1'h1
`define PIR_BUILD_PARAMS_ENCODED 1'h1
`define PIR_INPUT_FILTER_PRESENT 1'h0
`define PIR_FIRST_PORT_IRQ_PRESENT 1'h0
`define PIR_BIT_IDENT_REG 15
`define PIR_BIT_PARAMS_ENC 14
`define PIR_BIT_FILTER 13
`define PIR_BIT_PORT_IRQ 12
`define PIR_WIDTH_LSB 16
`define PIR_WIDTH_MSB 20
`endif

// ==== src/pir_pkg.sv ====
// Purpose: Types of the ident/build-option bank
// Assumes: Nothing
// Notes: Register selector is one-hot
package pir_pkg;
  typedef enum logic [3:0] {
    PIR_SEL_NONE = 4'b0001,
    PIR_SEL_IDENT = 4'b0010,
    PIR_SEL_VERSION = 4'b0100,
    PIR_SEL_OPTS = 4'b1000
  } pir_sel_t;
endpackage

// ==== src/pir_decode.sv ====
// Purpose: Address decode of the bank
// Assumes: Aligned byte addresses
// Notes: Pure combinational
`timescale 1ns/1ps
`include "pir_regs.svh"
module pir_decode (
  input wire logic [7:0] addr_in,
  output pir_pkg::pir_sel_t sel_out
);
  always_comb begin
    unique case (addr_in)
      `PIR_OFF_IDENT_CODE: sel_out = pir_pkg::PIR_SEL_IDENT;
      `PIR_OFF_COMP_VERSION: sel_out = pir_pkg::PIR_SEL_VERSION;
      `PIR_OFF_BUILD_OPT1: sel_out = pir_pkg::PIR_SEL_OPTS;
      default: sel_out = pir_pkg::PIR_SEL_NONE;
    endcase
  end
endmodule // pir_decode

// ==== src/port_ident_param_regs.sv ====
// Purpose: Read-only identification and build-option registers on APB
// Assumes: Single clock core_clk_in, synchronous active-high reset_in
// Notes: Zero-wait-state slave; unmapped addresses read zero with pslverr
// Operation
// - Ident register low 16 bits give fixed build-time code; upper bits reserved zero.
// - Version register returns 32-bit value, one ASCII character per version digit.
// - Build-options bits 20:16 hold ident width minus one; bits above reserved.
// - Build-options bit 15 shows whether ident register was built in.
// - Build-options bit 14 shows whether encoded build parameters were added.
// - Build-options bit 13 shows whether input input_filter_present logic was built in.
// - Build-options bit 12 shows whether port A interrupts were built in.
`timescale 1ns/1ps
`include "pir_regs.svh"
module port_ident_param_regs (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  pir_pkg::pir_sel_t sel;
  logic [31:0] ident_word;
  logic [31:0] version_word;
  logic [31:0] opts_word;
  logic [31:0] rd_next;
  logic [31:0] prdata_reg;
  logic err_next;
  logic access;
  logic setup;

  pir_decode u_decode (
    .addr_in(paddr_in),
    .sel_out(sel)
  );

  assign ident_word = {16'h0000, `PIR_IDENT_CODE_VAL};
  assign version_word = `PIR_COMP_VERSION_VAL;
  always_comb begin
    opts_word = 32'h0000_0000;
    opts_word[`PIR_WIDTH_MSB:`PIR_WIDTH_LSB] = 5'(`PIR_IDENT_FIELD_WIDTH_PARAM - 6'h01);
    opts_word[`PIR_BIT_IDENT_REG] = `PIR_IDENT_REG_PRESENT;
    opts_word[`PIR_BIT_PARAMS_ENC] = `PIR_BUILD_PARAMS_ENCODED;
    opts_word[`PIR_BIT_FILTER] = `PIR_INPUT_FILTER_PRESENT;
    opts_word[`PIR_BIT_PORT_IRQ] = `PIR_FIRST_PORT_IRQ_PRESENT;
  end

  // Writes return zero data, unmapped writes still flag error; read mux is side-effect free
  always_comb begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    unique case (sel)
      pir_pkg::PIR_SEL_IDENT: rd_next = ident_word;
      pir_pkg::PIR_SEL_VERSION: rd_next = version_word;
      pir_pkg::PIR_SEL_OPTS: rd_next = opts_word;
      pir_pkg::PIR_SEL_NONE: err_next = 1'b1;
    endcase
    if (pwrite_in) begin
      rd_next = 32'h0000_0000;
    end
  end

  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;

  // Read data captured in setup, held through access
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= rd_next;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = 1'b1;
  assign pslverr_out = access && err_next;

  logic was_access;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      was_access <= 1'b0;
    end else begin
      was_access <= access;
    end
  end

  // Last word read from each register, for the side-effect check
  logic [31:0] seen_word [3];
  logic [2:0] seen_valid;
  logic [1:0] seen_idx;
  logic seen_hit;

  always_comb begin
    seen_idx = 2'h0;
    seen_hit = 1'b1;
    unique case (sel)
      pir_pkg::PIR_SEL_IDENT: seen_idx = 2'h0;
      pir_pkg::PIR_SEL_VERSION: seen_idx = 2'h1;
      pir_pkg::PIR_SEL_OPTS: seen_idx = 2'h2;
      pir_pkg::PIR_SEL_NONE: seen_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      seen_valid <= 3'h0;
    end else if (access && !pwrite_in && seen_hit) begin
      seen_valid[seen_idx] <= 1'b1;
      seen_word[seen_idx] <= prdata_out;
    end
  end

  // Read data per register
  a_ident_read: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && paddr_in == `PIR_OFF_IDENT_CODE
    |-> prdata_out[31:16] == 16'h0000 && prdata_out[15:0] == `PIR_IDENT_CODE_VAL
  ) else $error("ident read wrong");
  a_version_read: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && paddr_in == `PIR_OFF_COMP_VERSION
    |-> prdata_out == `PIR_COMP_VERSION_VAL
  ) else $error("version read wrong");
  a_version_ascii: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && paddr_in == `PIR_OFF_COMP_VERSION
    |-> prdata_out[31:24] inside {[8'h20:8'h7e]} && prdata_out[23:16] inside {[8'h20:8'h7e]}
      && prdata_out[15:8] inside {[8'h20:8'h7e]} && prdata_out[7:0] inside {[8'h20:8'h7e]}
  ) else $error("version not ASCII");
  a_width_field: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && paddr_in == `PIR_OFF_BUILD_OPT1
    |-> prdata_out[31:21] == 11'h000 && prdata_out[20:16] == 5'h0f
  ) else $error("width field wrong");
  a_ident_present: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && paddr_in == `PIR_OFF_BUILD_OPT1
    |-> prdata_out[15] == `PIR_IDENT_REG_PRESENT
  ) else $error("ident present bit wrong");
  a_params_enc: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && paddr_in == `PIR_OFF_BUILD_OPT1
    |-> prdata_out[14] == `PIR_BUILD_PARAMS_ENCODED
  ) else $error("encoded params bit wrong");
  a_filter_bit: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && paddr_in == `PIR_OFF_BUILD_OPT1
    |-> prdata_out[13] == `PIR_INPUT_FILTER_PRESENT
  ) else $error("input_filter_present bit wrong");
  a_port_irq_bit: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && paddr_in == `PIR_OFF_BUILD_OPT1
    |-> prdata_out[12] == `PIR_FIRST_PORT_IRQ_PRESENT && prdata_out[11:0] == 12'h000
  ) else $error("port irq bit wrong");

  // Bus answer, hold and reset
  a_pready_high: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access
    |-> pready_out
  ) else $error("access without ready");
  a_err_access_only: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    !access
    |-> !pslverr_out
  ) else $error("error outside access");
  a_unmapped_err: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && sel == pir_pkg::PIR_SEL_NONE
    |-> pslverr_out && prdata_out == 32'h0000_0000
  ) else $error("unmapped not flagged");
  a_data_hold: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    !setup && !reset_in
    |=> $stable(prdata_out)
  ) else $error("read data moved outside setup");
  a_reset_clear: assert property (
    @(posedge core_clk_in)
    reset_in
    |=> prdata_out == 32'h0000_0000 && !pslverr_out
  ) else $error("reset left read data");
  a_sel_onehot: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    1'b1
    |-> $onehot(sel)
  ) else $error("register select not one-hot");

  // Writes, no error on mapped access, and repeated reads
  a_write_zero: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && pwrite_in
    |-> prdata_out == 32'h0000_0000 && pready_out
  ) else $error("write not ignored");
  a_mapped_no_err: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && sel != pir_pkg::PIR_SEL_NONE
    |-> !pslverr_out
  ) else $error("mapped access flagged");
  a_read_stable: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in ##1 setup && !pwrite_in && $stable(paddr_in)
    |=> $stable(prdata_out)
  ) else $error("read changed value");
  a_repeat_read: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && seen_hit && seen_valid[seen_idx]
    |-> prdata_out == seen_word[seen_idx]
  ) else $error("repeated read differs");

  c_read_ident: cover property (@(posedge core_clk_in) access && !pwrite_in && paddr_in == `PIR_OFF_IDENT_CODE);
  c_read_opts: cover property (@(posedge core_clk_in) access && !pwrite_in && paddr_in == `PIR_OFF_BUILD_OPT1);
  c_write_any: cover property (@(posedge core_clk_in) access && pwrite_in);
  c_back_to_back: cover property (@(posedge core_clk_in) was_access && setup);
  c_unmapped: cover property (@(posedge core_clk_in) access && pslverr_out);
endmodule // port_ident_param_regs

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the ident/build-option bank
// Assumes: Zero-wait APB slave, sync active-high reset
// Notes: Expected words built from header build values
`timescale 1ns/1ps
`include "pir_regs.svh"
module tb_top;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  int fail_count = 0, num_checks = 0;
  logic [31:0] exp_id, exp_ver, exp_opt, rd_v;
  logic er;
  logic [4:0] wm1;
  port_ident_param_regs u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
  initial begin
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Request held until pready seen high; release left to idle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd_v = prdata;
    er = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(w, a, ~e);
    chk("prdata", e, rd_v);
    chk_flag("pslverr", ee, er);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(20 * 2000);
    fail_count++;
    stop_test();
  end
  initial begin
    wm1 = 5'(`PIR_IDENT_FIELD_WIDTH_PARAM - 6'h01);
    exp_id = {16'h0000, `PIR_IDENT_CODE_VAL};
    exp_ver = `PIR_COMP_VERSION_VAL;
    exp_opt = {11'h000, wm1, `PIR_IDENT_REG_PRESENT, `PIR_BUILD_PARAMS_ENCODED,
      `PIR_INPUT_FILTER_PRESENT, `PIR_FIRST_PORT_IRQ_PRESENT, 12'h000};
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    chk("reset prdata", 32'h0, prdata);
    xfer(1'b0, 8'h64, exp_id, 1'b0);
    xfer(1'b0, 8'h6c, exp_ver, 1'b0);
    xfer(1'b0, 8'h74, exp_opt, 1'b0);
    idle();
    $display("test reads done");
    xfer(1'b1, 8'h64, 32'h0, 1'b0);
    xfer(1'b0, 8'h64, exp_id, 1'b0);
    xfer(1'b1, 8'h6c, 32'h0, 1'b0);
    xfer(1'b0, 8'h6c, exp_ver, 1'b0);
    xfer(1'b1, 8'h74, 32'h0, 1'b0);
    xfer(1'b0, 8'h74, exp_opt, 1'b0);
    xfer(1'b0, 8'h74, exp_opt, 1'b0);
    idle();
    $display("test writes done");
    xfer(1'b0, 8'h68, 32'h0, 1'b1);
    xfer(1'b1, 8'h70, 32'h0, 1'b1);
    xfer(1'b0, 8'h00, 32'h0, 1'b1);
    xfer(1'b0, 8'h64, exp_id, 1'b0);
    idle();
    $display("test unmapped done");
    xfer(1'b0, 8'h6c, exp_ver, 1'b0);
    reset_in <= 1'b1;
    repeat (2) idle();
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    chk("mid reset prdata", 32'h0, prdata);
    xfer(1'b0, 8'h74, exp_opt, 1'b0);
    idle();
    $display("test reset done");
    stop_test();
  end
endmodule // tb_top
